// ### ctc_trigger_ctrl.sv
// camera capture trigger control: mode select, edge pacing, capture starts
// Operation
// - selecting a trigger mode in standby leaves standby and enters that mode
// - hardware mode holds a single capture request pending until the chosen edge
// - soft mode single capture request captures one image at once
// - soft mode continuous request repeats triggered captures until stopped
// - force command in hardware mode starts one capture without an edge, unless the sensor is busy
// - disabling the trigger puts the camera into freerun
// - with trigger disabled the trigger input level is readable
// - selection query returns the currently selected trigger mode
// - capability query returns all supported mode codes or-ed together
// - unsupported codes, force outside hardware mode and captures in standby are refused with an error
// - pre-trigger and synchronized edge modes unsupported and not reported
module ctc_trigger_ctrl
  import ctc_pkg::*;
#(
  parameter int CAPTURE_CYCLES = CTC_CAPTURE_CYC
)
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire ctc_pkg::ctc_cmd_s cmd_in,
  input wire logic trig_pin_in,
  output ctc_pkg::ctc_rsp_s rsp_out,
  output ctc_pkg::ctc_state_e state_out,
  output logic capture_start_out,
  output logic capture_busy_out,
  output logic pending_out,
  output logic continuous_out,
  output logic [7:0] selection_out
);
  import ctc_pkg::*;

  ctc_state_e state_reg;
  logic [7:0] sel_reg;
  logic pending_reg;
  logic cont_reg;
  logic start_reg;
  ctc_rsp_s rsp_reg;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic busy;
  logic hw_mode;
  logic soft_mode;
  logic edge_hit;
  logic start_now;
  logic sel_ok;
  logic req_bad;

  function automatic logic ctc_sel_supported(input logic [7:0] code);
    ctc_sel_supported = (code == CTC_SEL_DISABLED) || (code == CTC_SEL_HW_FALLING) ||
      (code == CTC_SEL_HW_RISING) || (code == CTC_SEL_SOFT);
  endfunction : ctc_sel_supported

  ctc_edge_det u_edge
  (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .pin_in(trig_pin_in),
    .level_out(pin_level),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  ctc_capture_timer #(.CYCLES(CAPTURE_CYCLES)) u_timer
  (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .start_in(start_now),
    .busy_out(busy),
    .done_out()
  );

  assign hw_mode = (state_reg == CTC_ST_TRIGGER) &&
    (sel_reg == CTC_SEL_HW_FALLING || sel_reg == CTC_SEL_HW_RISING);
  assign soft_mode = (state_reg == CTC_ST_TRIGGER) && (sel_reg == CTC_SEL_SOFT);
  // edge chosen by the selection
  assign edge_hit = hw_mode &&
    ((sel_reg == CTC_SEL_HW_FALLING) ? pin_fall : pin_rise);
  // pre and sync codes are rejected here, so they never become a mode
  assign sel_ok = ctc_sel_supported(cmd_in.sel_code);

  // a request is wrong for the state: unsupported code, force outside
  // hardware mode, or any capture while in standby
  always_comb
  begin
    req_bad = 1'b0;
    if (cmd_in.sel_valid && !sel_ok)
      req_bad = 1'b1;
    if (cmd_in.force_capture && !hw_mode)
      req_bad = 1'b1;
    if ((cmd_in.single_capture || cmd_in.continuous_capture) &&
        state_reg == CTC_ST_STANDBY)
      req_bad = 1'b1;
  end

  // capture start: a busy sensor delays pending and continuous starts, but a force or an edge that comes while busy is dropped
  always_comb
  begin
    start_now = 1'b0;
    if (!busy)
    begin
      if (state_reg == CTC_ST_FREERUN)
        start_now = 1'b1;
      else if (soft_mode && (cont_reg || pending_reg))
        start_now = 1'b1;
      else if (hw_mode && pending_reg && edge_hit)
        start_now = 1'b1;
      else if (hw_mode && cmd_in.force_capture)
        start_now = 1'b1;
    end
  end

  // operating state and selection
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= CTC_ST_FREERUN;
      sel_reg <= CTC_SEL_RESET;
    end
    else if (cmd_in.sel_valid && sel_ok)
    begin
      sel_reg <= cmd_in.sel_code;
      if (cmd_in.sel_code == CTC_SEL_DISABLED)
        state_reg <= CTC_ST_FREERUN;
      else
        state_reg <= CTC_ST_TRIGGER;
    end
    else if (cmd_in.standby)
      state_reg <= CTC_ST_STANDBY;
  end

  // pending single request; a hardware edge only serves a waiting request
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      pending_reg <= 1'b0;
    else if (cmd_in.sel_valid || cmd_in.standby)
      pending_reg <= 1'b0;
    else if (cmd_in.single_capture && state_reg == CTC_ST_TRIGGER)
      pending_reg <= 1'b1;
    else if (start_now && (hw_mode ? edge_hit : soft_mode))
      pending_reg <= 1'b0;
  end

  // continuous sequence in soft mode
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      cont_reg <= 1'b0;
    else if (cmd_in.sel_valid || cmd_in.standby || cmd_in.stop_capture)
      cont_reg <= 1'b0;
    else if (cmd_in.continuous_capture && soft_mode)
      cont_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      start_reg <= 1'b0;
    else
      start_reg <= start_now;
  end

  // query answers and error flag, one cycle after the command
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      rsp_reg <= '0;
    else
    begin
      rsp_reg.done <= cmd_in.query_valid || cmd_in.sel_valid || cmd_in.force_capture ||
        cmd_in.single_capture || cmd_in.continuous_capture;
      rsp_reg.err_capture_state <= req_bad;
      rsp_reg.data <= 8'h00;
      if (cmd_in.query_valid)
      begin
        case (cmd_in.query_code)
          CTC_Q_SELECTION: rsp_reg.data <= sel_reg;
          CTC_Q_INPUT_LEVEL: rsp_reg.data <= {7'h00, pin_level};
          CTC_Q_CAPABILITIES: rsp_reg.data <= CTC_CAPS;
          default: rsp_reg.data <= 8'h00;
        endcase
      end
    end
  end

  assign rsp_out = rsp_reg;
  assign state_out = state_reg;
  assign capture_start_out = start_reg;
  assign capture_busy_out = busy;
  assign pending_out = pending_reg;
  assign continuous_out = cont_reg;
  assign selection_out = sel_reg;
endmodule : ctc_trigger_ctrl

// ### ctc_pkg.sv
// package: trigger selection codes, states and command/status carriers
package ctc_pkg;
  localparam int CTC_SEL_W = 8;
  // selection codes, one bit each except disabled (zero), so capabilities can be or-ed together
  localparam logic [7:0] CTC_SEL_DISABLED = 8'h00;
  localparam logic [7:0] CTC_SEL_HW_FALLING = 8'h01;
  localparam logic [7:0] CTC_SEL_HW_RISING = 8'h02;
  localparam logic [7:0] CTC_SEL_PRE_FALLING = 8'h04;
  localparam logic [7:0] CTC_SEL_PRE_RISING = 8'h08;
  localparam logic [7:0] CTC_SEL_SYNC_FALLING = 8'h10;
  localparam logic [7:0] CTC_SEL_SYNC_RISING = 8'h20;
  localparam logic [7:0] CTC_SEL_SOFT = 8'h40;
  localparam logic [7:0] CTC_SEL_RESET = 8'h00;
  localparam logic [7:0] CTC_CAPS =
    CTC_SEL_HW_FALLING | CTC_SEL_HW_RISING | CTC_SEL_SOFT;
  // query codes
  localparam logic [1:0] CTC_Q_SELECTION = 2'h0;
  localparam logic [1:0] CTC_Q_INPUT_LEVEL = 2'h1;
  localparam logic [1:0] CTC_Q_CAPABILITIES = 2'h2;
  // one capture lasts this many cycles (sensor busy), 100 us at 20 MHz
  localparam int CTC_CLK_HZ = 20000000;
  localparam int CTC_CAPTURE_US = 100;
  localparam int CTC_CAPTURE_CYC = CTC_CAPTURE_US * (CTC_CLK_HZ / 1000000);
  typedef enum logic [1:0] {CTC_ST_STANDBY, CTC_ST_FREERUN, CTC_ST_TRIGGER} ctc_state_e;
  typedef struct packed {
    logic sel_valid;
    logic [7:0] sel_code;
    logic standby;
    logic single_capture;
    logic continuous_capture;
    logic stop_capture;
    logic force_capture;
    logic query_valid;
    logic [1:0] query_code;
  } ctc_cmd_s;
  typedef struct packed {
    logic done;
    logic err_capture_state;
    logic [7:0] data;
  } ctc_rsp_s;
endpackage : ctc_pkg

// ### ctc_edge_det.sv
// synchroniser and edge detector for the external trigger pin
module ctc_edge_det
  import ctc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  // first flop feeds only the second one
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level_out = sync_reg;
  assign rise_out = sync_reg & ~last_reg;
  assign fall_out = ~sync_reg & last_reg;
endmodule : ctc_edge_det

// ### ctc_capture_timer.sv
// capture pacing timer: busy for a fixed number of cycles after a start
module ctc_capture_timer
  import ctc_pkg::*;
#(
  parameter int CYCLES = CTC_CAPTURE_CYC
)
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  logic done_reg;
  // a zero length would never mark the sensor busy and let starts pile up
  if (CYCLES < 1)
  begin : g_len_chk
    $error("capture length must be at least one cycle");
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= (cnt_reg == CW'(1));
      if (start_in && cnt_reg == '0)
        cnt_reg <= CW'(CYCLES);
      else if (cnt_reg != '0)
        cnt_reg <= cnt_reg - CW'(1);
    end
  end
  assign busy_out = (cnt_reg != '0);
  assign done_out = done_reg;
endmodule : ctc_capture_timer

// ### ctc_trig_src.sv
// external trigger source model: drives the pin a while after a level request
module ctc_trig_src
(
  input wire logic lvl_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // skewed off both clock edges, as a real async source would be
  initial pin_out = 1'b0;
  always @(lvl_in) pin_out <= #13 lvl_in;
endmodule : ctc_trig_src

// ### ctc_trigger_ctrl_asserts.sv
// port checks for the capture trigger control
module ctc_trigger_ctrl_asserts
  import ctc_pkg::*;
#(
  parameter int CAPTURE_CYCLES = CTC_CAPTURE_CYC
)
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire ctc_pkg::ctc_cmd_s cmd_in,
  input wire logic trig_pin_in,
  input wire ctc_pkg::ctc_rsp_s rsp_out,
  input wire ctc_pkg::ctc_state_e state_out,
  input wire logic capture_start_out,
  input wire logic capture_busy_out,
  input wire logic pending_out,
  input wire logic continuous_out,
  input wire logic [7:0] selection_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic hw;
  logic sv;
  assign hw = selection_out inside {8'h01, 8'h02};
  assign sv = cmd_in.sel_valid;
  // six quiet samples cover the sync and edge stages
  sequence quiet_s;
    (!trig_pin_in && !cmd_in.force_capture && selection_out == 8'h02
      && state_out == CTC_ST_TRIGGER)[*6];
  endsequence
  sequence soft_req_s;
    cmd_in.single_capture && selection_out == 8'h40 && state_out == CTC_ST_TRIGGER
      && !capture_busy_out && !pending_out && !continuous_out;
  endsequence
  caps_query_a: assert property (cmd_in.query_valid && cmd_in.query_code == 2'h2
    |=> rsp_out.done && rsp_out.data == 8'h43) else $error("bad caps");
  sel_query_a: assert property (cmd_in.query_valid && cmd_in.query_code == 2'h0 && !sv
    |=> rsp_out.data == $past(selection_out)) else $error("bad selection read");
  bad_sel_a: assert property (sv && !(cmd_in.sel_code inside {8'h00, 8'h01, 8'h02, 8'h40})
    |=> rsp_out.err_capture_state && $stable(selection_out)) else $error("bad code taken");
  sby_exit_a: assert property (state_out == CTC_ST_STANDBY && sv && cmd_in.sel_code == 8'h02
    |=> state_out == CTC_ST_TRIGGER) else $error("standby kept");
  off_run_a: assert property (sv && cmd_in.sel_code == 8'h00
    |=> state_out == CTC_ST_FREERUN && selection_out == 8'h00) else $error("no freerun");
  sby_refuse_a: assert property (state_out == CTC_ST_STANDBY && cmd_in.single_capture && !sv
    |=> rsp_out.err_capture_state) else $error("standby capture taken");
  force_err_a: assert property (cmd_in.force_capture && !sv && !hw
    |=> rsp_out.err_capture_state) else $error("force not refused");
  force_go_a: assert property (cmd_in.force_capture && hw && state_out == CTC_ST_TRIGGER
    && !capture_busy_out |-> ##[1:3] capture_start_out) else $error("force lost");
  hw_hold_a: assert property (quiet_s |-> !capture_start_out) else $error("start w/o edge");
  soft_go_a: assert property (soft_req_s |-> ##[1:3] capture_start_out) else $error("no soft start");
endmodule : ctc_trigger_ctrl_asserts

bind ctc_trigger_ctrl ctc_trigger_ctrl_asserts #(.CAPTURE_CYCLES(CAPTURE_CYCLES)) chk_i (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cmd_in(cmd_in), .trig_pin_in(trig_pin_in),
  .rsp_out(rsp_out), .state_out(state_out), .capture_start_out(capture_start_out),
  .capture_busy_out(capture_busy_out), .pending_out(pending_out),
  .continuous_out(continuous_out), .selection_out(selection_out));

// ### testbench.sv
// self-checking bench for the capture trigger control
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ctc_pkg::*;
  localparam int SEL = 0, SBY = 1, SGL = 2, CNT = 3, STP = 4, FRC = 5, QRY = 6;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic lvl = 1'b0;
  logic pin;
  logic start, busy, pend, cont;
  logic [7:0] sel, nst = 8'h00, n0;
  ctc_cmd_s cmd;
  ctc_rsp_s rsp, got;
  ctc_state_e st;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  initial forever #25 ref_clk_in = ~ref_clk_in;
  ctc_trig_src ctc_trig_src_i (.lvl_in(lvl), .pin_out(pin));
  ctc_trigger_ctrl #(.CAPTURE_CYCLES(4)) ctc_trigger_ctrl_i (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .cmd_in(cmd), .trig_pin_in(pin), .rsp_out(rsp), .state_out(st),
    .capture_start_out(start), .capture_busy_out(busy), .pending_out(pend),
    .continuous_out(cont), .selection_out(sel));
  // counted at the rising edge so reads at the falling edge never race it
  always @(posedge ref_clk_in)
  begin
    nst <= nst + 8'(start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      results();
    end
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task idle(input int n);
    // cleared here, not at the end of op, so back-to-back commands write once per step
    cmd = '0;
    repeat (n) @(negedge ref_clk_in);
  endtask : idle
  task op(input int k, input logic [7:0] v);
    ctc_cmd_s c;
    c = '0;
    case (k)
      SEL: {c.sel_valid, c.sel_code} = {1'b1, v};
      SBY: c.standby = 1'b1;
      SGL: c.single_capture = 1'b1;
      CNT: c.continuous_capture = 1'b1;
      STP: c.stop_capture = 1'b1;
      FRC: c.force_capture = 1'b1;
      default: {c.query_valid, c.query_code} = {1'b1, v[1:0]};
    endcase
    cmd = c;
    @(negedge ref_clk_in);
    got = rsp;
  endtask : op
  task t_query();
    op(QRY, CTC_Q_CAPABILITIES);
    chk(got.data, CTC_SEL_HW_FALLING | CTC_SEL_HW_RISING | CTC_SEL_SOFT);
    chk(got.done, 8'h01);
    op(QRY, CTC_Q_SELECTION);
    chk(got.data, CTC_SEL_DISABLED);
    chk(st, CTC_ST_FREERUN);
    repeat (2)
    begin
      lvl = ~lvl;
      idle(5);
      op(QRY, CTC_Q_INPUT_LEVEL);
      chk(got.data, {7'h00, lvl});
    end
    $display("query test done");
  endtask : t_query
  task t_hw();
    op(SBY, 8'h00);
    op(SGL, 8'h00);
    chk(got.err_capture_state, 1);
    op(SEL, CTC_SEL_HW_RISING);
    chk(st, CTC_ST_TRIGGER);
    n0 = nst;
    op(SGL, 8'h00);
    idle(8);
    chk(nst - n0, 0);
    chk(pend, 1);
    lvl = 1'b1;
    idle(8);
    chk(nst - n0, 1);
    op(SGL, 8'h00);
    lvl = 1'b0;
    idle(8);
    chk(nst - n0, 8'h01);
    chk(pend, 8'h01);
    op(SEL, CTC_SEL_HW_FALLING);
    op(SGL, 8'h00);
    n0 = nst;
    lvl = 1'b1;
    idle(8);
    chk(nst - n0, 8'h00);
    op(FRC, 8'h00);
    chk(busy, 8'h01);
    idle(8);
    chk(nst - n0, 1);
    chk(busy, 8'h00);
    op(SGL, 8'h00);
    lvl = 1'b0;
    idle(8);
    chk(nst - n0, 2);
    $display("hardware test done");
  endtask : t_hw
  task t_soft();
    logic [7:0] bad [4] = '{8'h04, 8'h08, 8'h10, 8'h20};
    foreach (bad[i])
    begin
      op(SEL, bad[i]);
      chk(got.err_capture_state, 8'h01);
      chk(sel, CTC_SEL_HW_FALLING);
    end
    op(SEL, CTC_SEL_SOFT);
    op(FRC, 8'h00);
    chk(got.err_capture_state, 1);
    n0 = nst;
    op(SGL, 8'h00);
    idle(6);
    chk(nst - n0, 1);
    op(CNT, 8'h00);
    chk(cont, 8'h01);
    idle(30);
    chk(8'(nst - n0 > 3), 1);
    op(STP, 8'h00);
    chk(cont, 8'h00);
    idle(6);
    n0 = nst;
    idle(20);
    chk(nst - n0, 0);
    op(SEL, CTC_SEL_DISABLED);
    chk(st, CTC_ST_FREERUN);
    $display("soft test done");
  endtask : t_soft
  task results();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    idle(12);
    rstn_in = 1'b1;
    t_query();
    t_hw();
    t_soft();
    results();
  end
endmodule : testbench
